/* File: mtseq_pkg.sv */
// shared constants and types for the measurement trigger sequencer
package mtseq_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [6:0]  TICK_LAST     = 7'(TICK_CYCLES - 1);

    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CMD     = 8'h04;
    localparam logic [7:0] ADDR_SOURCE  = 8'h08;
    localparam logic [7:0] ADDR_TIMER   = 8'h0C;
    localparam logic [7:0] ADDR_DELAY   = 8'h10;
    localparam logic [7:0] ADDR_TCOUNT  = 8'h14;
    localparam logic [7:0] ADDR_SCOUNT  = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1C;
    localparam logic [7:0] ADDR_MASK    = 8'h20;
    localparam logic [7:0] ADDR_STATE   = 8'h24;
    localparam logic [7:0] ADDR_DONE    = 8'h28;

    localparam int CMD_ABORT    = 0;
    localparam int CMD_INIT     = 1;
    localparam int CMD_READ     = 2;
    localparam int CMD_SIGNAL   = 3;
    localparam int CMD_BUSTRIG  = 4;
    localparam int CMD_RST      = 5;
    localparam int CMD_PRESET   = 6;
    localparam int CMD_MANUAL   = 7;
    localparam int CMD_FETCH    = 8;

    localparam int CTRL_CONT    = 0;
    localparam int CTRL_AUTODLY = 1;

    localparam int ST_ERR       = 0;
    localparam int ST_OUTTRIG   = 1;
    localparam int ST_DONE      = 2;
    localparam int ST_SAMPLE    = 3;
    localparam int ST_FETCH     = 4;
    localparam int ST_W         = 5;

    // times in milliseconds; timer and delay fields count ms
    localparam logic [31:0] TIME_MAX_MS     = 32'h3B9AC9FF;
    localparam logic [31:0] TIMER_DEF_MS    = 32'h00000064;
    localparam logic [31:0] DELAY_DEF_MS    = 32'h00000000;
    localparam logic [31:0] MS_IN_US        = 32'h000003E8;
    localparam logic [16:0] COUNT_MAX       = 17'h1ADB0;
    localparam logic [16:0] COUNT_ONE       = 17'h00001;
    localparam logic [16:0] COUNT_UNBOUNDED = 17'h00000;

    typedef enum logic [2:0] {
        source_immediate = 3'h0,
        source_timer     = 3'h1,
        source_manual    = 3'h2,
        source_bus       = 3'h3,
        source_external  = 3'h4
    } mtseq_src_t;

    typedef enum logic [2:0] {
        MT_IDLE   = 3'h0,
        MT_WAIT   = 3'h1,
        MT_TIMED  = 3'h2,
        MT_ACTION = 3'h3,
        MT_NEXT   = 3'h4
    } mtseq_state_t;
endpackage

/* File: mtseq_ms_timer.sv */
// millisecond down-counter used for timer and delay waits
`timescale 1ns/1ns
module mtseq_ms_timer
    import mtseq_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        start_in,
    input  wire logic [31:0] ms_in,
    output logic             busy_out
);
    import mtseq_pkg::*;

    logic [6:0]  tick_ff;
    logic [9:0]  us_ff;
    logic [31:0] ms_ff;
    logic        busy_ff;

    assign busy_out = busy_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_ff <= 7'h00;
            us_ff   <= 10'h000;
            ms_ff   <= 32'h00000000;
            busy_ff <= 1'b0;
        end else if (start_in) begin
            tick_ff <= 7'h00;
            us_ff   <= 10'h000;
            ms_ff   <= ms_in;
            busy_ff <= (ms_in != 32'h00000000);
        end else if (busy_ff) begin
            if (tick_ff == TICK_LAST) begin
                tick_ff <= 7'h00;
                if (us_ff == 10'(MS_IN_US - 32'h1)) begin
                    us_ff <= 10'h000;
                    ms_ff <= ms_ff - 32'h1;
                    if (ms_ff == 32'h00000001) begin
                        busy_ff <= 1'b0;
                    end
                end else begin
                    us_ff <= us_ff + 10'h001;
                end
            end else begin
                tick_ff <= tick_ff + 7'h01;
            end
        end
    end
endmodule

/* File: mtseq_top.sv */
// trigger sequencer with command port, settings and status registers
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
// Operation
// RULE1 - abort goes idle, or restarts at the top when continuous is on
// RULE2 - initiate starts one cycle from idle; while active it errors, ignored
// RULE3 - continuous on rejects read and sample counts above one
// RULE4 - read performs abort, initiate, then fetch, in that order
// RULE5 - source selects immediate, timer, manual, bus, external; immediate default
// RULE6 - timer interval 0 to 999999.999 s, default 0.1 s, used by timer source
// RULE7 - trigger count 1 to 110000 or unbounded; reset gives 1
// RULE8 - preset sets continuous on, count unbounded; reset clears continuous
// RULE9 - delay 0 to 999999.999 s, default zero
// RULE10 - turning auto delay off forces delay to zero
// RULE11 - signal passes the control source only while waiting there, else error
// RULE12 - sample count 1 to 110000, default 1; above one stores each reading
// RULE13 - standard reset restores all defaults and leaves the sequencer idle
// RULE14 - timer source bypasses first pass, later waits max of timer and delay
// RULE15 - external satisfied by link input pulse, bus by bus trigger command
// RULE16 - output trigger pulse after each completed sample loop
// RULE17 - each rejected command sets a sticky readable clearable error flag; out-of-range source, timer, delay and trigger count writes set none
module mtseq_top
    import mtseq_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        link_trig_in,
    output logic [31:0]      rdata_out,
    output logic             out_trig_out,
    output logic             action_out,
    output logic             store_out,
    output logic             irq_out
);
    import mtseq_pkg::*;

    mtseq_state_t state_ff;
    mtseq_state_t nxt_state;
    mtseq_src_t   source_ff;
    logic        cont_ff;
    logic        autodly_ff;
    logic [31:0] timer_ff;
    logic [31:0] delay_ff;
    logic [16:0] tcount_ff;
    logic [16:0] scount_ff;
    logic [16:0] tdone_ff;
    logic [16:0] sdone_ff;
    logic        first_ff;
    logic [ST_W-1:0] status_ff;
    logic [ST_W-1:0] mask_ff;
    logic [31:0] rdata_ff;
    logic        out_trig_ff;
    logic        action_ff;
    logic        store_ff;
    logic        irq_ff;
    logic        link_s1_ff;
    logic        link_s2_ff;
    logic        link_s3_ff;
    logic [31:0] wait_ms;
    logic        tmr_start;
    logic        tmr_busy;

    // command decode
    logic        cmd_wr;
    logic        c_abort;
    logic        c_init;
    logic        c_read;
    logic        c_signal;
    logic        c_bus;
    logic        c_rst;
    logic        c_preset;
    logic        c_manual;
    logic        c_fetch;
    logic        read_ok;
    logic        init_ok;
    logic        signal_ok;
    logic        scount_bad;
    logic        err_ev;
    logic        event_hit;
    logic        restart;
    logic        link_pulse;
    logic        loop_done;
    logic        trig_done;
    logic        status_rd;

    assign cmd_wr    = wr_in && (addr_in == ADDR_CMD);
    assign c_abort   = cmd_wr && wdata_in[CMD_ABORT];
    assign c_init    = cmd_wr && wdata_in[CMD_INIT];
    assign c_read    = cmd_wr && wdata_in[CMD_READ];
    assign c_signal  = cmd_wr && wdata_in[CMD_SIGNAL];
    assign c_bus     = cmd_wr && wdata_in[CMD_BUSTRIG];
    assign c_rst     = cmd_wr && wdata_in[CMD_RST];
    assign c_preset  = cmd_wr && wdata_in[CMD_PRESET];
    assign c_manual  = cmd_wr && wdata_in[CMD_MANUAL];
    assign c_fetch   = cmd_wr && wdata_in[CMD_FETCH];
    assign status_rd = rd_in && (addr_in == ADDR_STATUS);

    assign read_ok    = c_read && !cont_ff; // RULE3
    assign init_ok    = c_init && (state_ff == MT_IDLE); // RULE2
    assign signal_ok  = c_signal && (state_ff == MT_WAIT); // RULE11
    // full word compared so high bits cannot alias into range
    assign scount_bad = wr_in && (addr_in == ADDR_SCOUNT) && ((wdata_in == 32'h0)
                        || (wdata_in > {15'h0, (cont_ff ? COUNT_ONE : COUNT_MAX)})); // RULE3
    assign err_ev = (c_read && cont_ff) || (c_init && !init_ok)
                  || (c_signal && !signal_ok) || scount_bad; // RULE17

    // edge on the synchronised link input
    assign link_pulse = link_s2_ff && !link_s3_ff; // RULE15

    always_comb begin
        case (source_ff)
            source_immediate: event_hit = 1'b1;
            source_timer:     event_hit = 1'b1;
            source_manual:    event_hit = c_manual;
            source_bus:       event_hit = c_bus; // RULE15
            source_external:  event_hit = link_pulse; // RULE15
            default:          event_hit = 1'b0;
        endcase
    end

    // timer source waits for the larger of timer and delay, but skips the first pass
    always_comb begin
        if (source_ff == source_timer) begin
            if (first_ff) begin
                wait_ms = delay_ff; // RULE14
            end else begin
                wait_ms = (timer_ff > delay_ff) ? timer_ff : delay_ff; // RULE14
            end
        end else begin
            wait_ms = delay_ff;
        end
    end

    assign loop_done = (sdone_ff + 17'h1) >= scount_ff;
    assign trig_done = (tcount_ff != COUNT_UNBOUNDED) && ((tdone_ff + 17'h1) >= tcount_ff);

    // abort with continuous on re-enters the flow; read re-initiates after abort
    assign restart = ((c_abort || c_preset) && (cont_ff || c_preset)) || read_ok; // RULE1 RULE4

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MT_IDLE: begin
                if (init_ok || cont_ff) begin
                    nxt_state = MT_WAIT;
                end
            end
            MT_WAIT: begin
                if (event_hit || signal_ok) begin
                    nxt_state = MT_TIMED; // RULE11
                end
            end
            MT_TIMED: begin
                if (!tmr_busy && !tmr_start) begin
                    nxt_state = MT_ACTION;
                end
            end
            MT_ACTION: begin
                nxt_state = MT_NEXT;
            end
            MT_NEXT: begin
                if (!loop_done) begin
                    nxt_state = MT_TIMED;
                end else if (!trig_done) begin
                    nxt_state = MT_WAIT;
                end else begin
                    nxt_state = MT_IDLE;
                end
            end
            default: nxt_state = MT_IDLE;
        endcase
        if (c_rst) begin
            nxt_state = MT_IDLE; // RULE13
        end else if (restart) begin
            nxt_state = MT_WAIT; // RULE1 RULE4
        end else if (c_abort) begin
            nxt_state = MT_IDLE; // RULE1
        end
    end

    assign tmr_start = (state_ff != MT_TIMED) && (nxt_state == MT_TIMED);

    mtseq_ms_timer u_timer (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .start_in  (tmr_start),
        .ms_in     (wait_ms),
        .busy_out  (tmr_busy)
    );

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            link_s1_ff <= 1'b0;
            link_s2_ff <= 1'b0;
            link_s3_ff <= 1'b0;
        end else begin
            link_s1_ff <= link_trig_in;
            link_s2_ff <= link_s1_ff;
            link_s3_ff <= link_s2_ff;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= MT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // loop counters and first-pass marker
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tdone_ff <= 17'h0;
            sdone_ff <= 17'h0;
            first_ff <= 1'b1;
        end else if (nxt_state == MT_IDLE || restart) begin
            tdone_ff <= 17'h0;
            sdone_ff <= 17'h0;
            first_ff <= 1'b1;
        end else if (state_ff == MT_NEXT) begin
            first_ff <= 1'b0;
            if (loop_done) begin
                sdone_ff <= 17'h0;
                tdone_ff <= tdone_ff + 17'h1;
            end else begin
                sdone_ff <= sdone_ff + 17'h1;
            end
        end
    end

    // settings
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cont_ff    <= 1'b0;
            autodly_ff <= 1'b0;
            source_ff  <= source_immediate;
            timer_ff   <= TIMER_DEF_MS;
            delay_ff   <= DELAY_DEF_MS;
            tcount_ff  <= COUNT_ONE;
            scount_ff  <= COUNT_ONE;
        end else if (c_rst) begin
            cont_ff    <= 1'b0; // RULE8 RULE13
            autodly_ff <= 1'b0;
            source_ff  <= source_immediate; // RULE5
            timer_ff   <= TIMER_DEF_MS; // RULE6
            delay_ff   <= DELAY_DEF_MS; // RULE9
            tcount_ff  <= COUNT_ONE; // RULE7
            scount_ff  <= COUNT_ONE; // RULE12
        end else if (c_preset) begin
            cont_ff   <= 1'b1; // RULE8
            tcount_ff <= COUNT_UNBOUNDED; // RULE8
            scount_ff <= COUNT_ONE;
        end else if (wr_in) begin
            if (addr_in == ADDR_CTRL) begin
                cont_ff    <= wdata_in[CTRL_CONT];
                autodly_ff <= wdata_in[CTRL_AUTODLY];
                if (!wdata_in[CTRL_AUTODLY]) begin
                    delay_ff <= DELAY_DEF_MS; // RULE10
                end
                if (wdata_in[CTRL_CONT]) begin
                    scount_ff <= COUNT_ONE;
                end
            end else if (addr_in == ADDR_SOURCE) begin
                if (wdata_in <= {29'h0, source_external}) begin
                    source_ff <= mtseq_src_t'(wdata_in[2:0]); // RULE5
                end
            end else if (addr_in == ADDR_TIMER) begin
                if (wdata_in <= TIME_MAX_MS) begin
                    timer_ff <= wdata_in; // RULE6
                end
            end else if (addr_in == ADDR_DELAY) begin
                if (wdata_in <= TIME_MAX_MS) begin
                    delay_ff <= wdata_in; // RULE9
                end
            end else if (addr_in == ADDR_TCOUNT) begin
                if (wdata_in <= {15'h0, COUNT_MAX}) begin
                    tcount_ff <= wdata_in[16:0]; // RULE7
                end
            end else if (addr_in == ADDR_SCOUNT) begin
                if (!scount_bad) begin
                    scount_ff <= wdata_in[16:0]; // RULE12
                end
            end else if (addr_in == ADDR_MASK) begin
            end
        end
    end

    // action, store and output trigger strobes
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            action_ff   <= 1'b0;
            store_ff    <= 1'b0;
            out_trig_ff <= 1'b0;
        end else begin
            action_ff   <= (state_ff == MT_ACTION);
            store_ff    <= (state_ff == MT_ACTION) && (scount_ff > COUNT_ONE); // RULE12
            out_trig_ff <= (state_ff == MT_NEXT) && loop_done; // RULE16
        end
    end

    // sticky status, set wins over read-clear
    logic [ST_W-1:0] ev_bits;
    assign ev_bits = {c_fetch || read_ok,
                      (state_ff == MT_ACTION),
                      (state_ff == MT_NEXT) && loop_done && trig_done,
                      (state_ff == MT_NEXT) && loop_done,
                      err_ev};

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_ff <= '0;
            mask_ff   <= '0;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= (status_rd ? '0 : status_ff) | ev_bits; // RULE17
            if (wr_in && addr_in == ADDR_MASK) begin
                mask_ff <= wdata_in[ST_W-1:0];
            end
            irq_ff <= |(((status_rd ? '0 : status_ff) | ev_bits) & mask_ff);
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_in) begin
            if (addr_in == ADDR_CTRL) begin
                rdata_ff <= {30'h0, autodly_ff, cont_ff};
            end else if (addr_in == ADDR_SOURCE) begin
                rdata_ff <= {29'h0, source_ff};
            end else if (addr_in == ADDR_TIMER) begin
                rdata_ff <= timer_ff;
            end else if (addr_in == ADDR_DELAY) begin
                rdata_ff <= delay_ff;
            end else if (addr_in == ADDR_TCOUNT) begin
                rdata_ff <= {15'h0, tcount_ff};
            end else if (addr_in == ADDR_SCOUNT) begin
                rdata_ff <= {15'h0, scount_ff};
            end else if (addr_in == ADDR_STATUS) begin
                rdata_ff <= {27'h0, status_ff};
            end else if (addr_in == ADDR_MASK) begin
                rdata_ff <= {27'h0, mask_ff};
            end else if (addr_in == ADDR_STATE) begin
                rdata_ff <= {29'h0, state_ff};
            end else if (addr_in == ADDR_DONE) begin
                rdata_ff <= {15'h0, tdone_ff};
            end else begin
                rdata_ff <= 32'h00000000;
            end
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign rdata_out    = rdata_ff;
    assign out_trig_out = out_trig_ff;
    assign action_out   = action_ff;
    assign store_out    = store_ff;
    assign irq_out      = irq_ff;
endmodule

/* File: mtseq_monitor.sv */
// assertion checker watching the trigger sequencer ports
`timescale 1ns/1ns
module mtseq_monitor
    import mtseq_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic        link_trig_in,
    input wire logic [31:0] rdata_out,
    input wire logic        out_trig_out,
    input wire logic        action_out,
    input wire logic        store_out,
    input wire logic        irq_out
);
    default clocking mon_cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_rdata_quiet: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside a read answer");
    chk_unmapped_read: assert property (rd_in && addr_in > ADDR_DONE |=> rdata_out == 32'h0)
        else $error("unmapped read returned data");
    chk_state_range: assert property (rd_in && addr_in == ADDR_STATE |=> rdata_out <= 32'h4)
        else $error("state code out of range");
    chk_store_with_action: assert property (store_out |-> action_out)
        else $error("store pulse without action pulse");
    chk_trig_single: assert property (out_trig_out |=> !out_trig_out)
        else $error("output trigger longer than one cycle");
    chk_trig_after_action: assert property (out_trig_out |-> $past(action_out))
        else $error("output trigger not right after an action");
    // a pending action pulse may still drain before the reset lands
    chk_reset_quiet: assert property (wr_in && addr_in == ADDR_CMD && wdata_in[CMD_RST]
        |-> ##3 !action_out [*4])
        else $error("action after standard reset");
    chk_irq_masked: assert property (wr_in && addr_in == ADDR_MASK && wdata_in == 32'h0
        |-> ##2 !irq_out)
        else $error("interrupt with all sources masked");

    cov_out_trig: cover property (out_trig_out);
    cov_store: cover property (store_out);
    cov_irq: cover property (irq_out);
    cov_link: cover property ($rose(link_trig_in));
endmodule

/* File: mtseq_link_src.sv */
// trigger link source driving pulses into the sequencer link input
`timescale 1ns/1ns
module mtseq_link_src (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic fire_in,
    output logic      link_out
);
    logic [2:0] width_ff;
    // wide enough to pass the two-flop synchroniser
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            width_ff <= 3'h0;
        end else if (fire_in) begin
            width_ff <= 3'h4;
        end else if (width_ff != 3'h0) begin
            width_ff <= width_ff - 3'h1;
        end
    end
    assign link_out = (width_ff != 3'h0);
endmodule

/* File: mtseq_test.sv */
// self-checking bench for the trigger sequencer
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module mtseq_test;
    import mtseq_pkg::*;
    logic        clk_in    = 1'b0;
    logic        resetn_in = 1'b0;
    logic [7:0]  addr_in   = 8'h00;
    logic [31:0] wdata_in  = 32'h0;
    logic        wr_in     = 1'b0;
    logic        rd_in     = 1'b0;
    logic        fire      = 1'b0;
    logic        link_trig_in;
    logic [31:0] rdata_out;
    logic        out_trig_out;
    logic        action_out;
    logic        store_out;
    logic        irq_out;
    logic [31:0] v;
    int          error_cnt = 0;
    int          checks = 0;
    int          n_act = 0;
    int          n_store = 0;
    int          n_trig = 0;
    int          a0, s0, t0;
    int          rel[2] = '{CMD_SIGNAL, CMD_MANUAL};

    mtseq_top i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .link_trig_in(link_trig_in),
        .rdata_out(rdata_out), .out_trig_out(out_trig_out), .action_out(action_out),
        .store_out(store_out), .irq_out(irq_out));
    mtseq_link_src i_src (.clk_in(clk_in), .resetn_in(resetn_in), .fire_in(fire),
        .link_out(link_trig_in));

    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        n_act   <= n_act + (action_out === 1'b1);
        n_store <= n_store + (store_out === 1'b1);
        n_trig  <= n_trig + (out_trig_out === 1'b1);
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 v = rdata_out;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK("read data", e, v)
    endtask

    task automatic cmd(input int b);
        wr(ADDR_CMD, 32'h1 << b);
    endtask

    task automatic wait_trig();
        int i;
        for (i = 0; i < 5000; i++) begin
            @(posedge clk_in);
            #1;
            if (out_trig_out === 1'b1) break;
        end
        if (i == 5000) begin
            error_cnt++;
            $display("mismatch out trigger exp 1 got timeout");
            stop_test();
        end
    endtask

    task automatic check_defaults();
        rdc(ADDR_SOURCE, 32'h0);
        rdc(ADDR_TIMER, TIMER_DEF_MS);
        rdc(ADDR_DELAY, DELAY_DEF_MS);
        rdc(ADDR_TCOUNT, 32'h1);
        rdc(ADDR_SCOUNT, 32'h1);
        rdc(ADDR_STATE, 32'h0);
        rd(ADDR_CTRL);
        `CHK("continuous", 1'b0, v[CTRL_CONT])
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        check_defaults();
        rdc(8'h2C, 32'h0);
        wr(ADDR_TIMER, 32'h3B9ACA00);
        rdc(ADDR_TIMER, TIMER_DEF_MS);
        wr(ADDR_TCOUNT, 32'h0001ADB1);
        rdc(ADDR_TCOUNT, 32'h1);
        wr(ADDR_TCOUNT, {15'h0, COUNT_MAX});
        rdc(ADDR_TCOUNT, {15'h0, COUNT_MAX});
        wr(ADDR_TCOUNT, 32'h1);
        wr(ADDR_SOURCE, 32'h5);
        rdc(ADDR_SOURCE, 32'h0);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_DELAY, TIME_MAX_MS);
        rdc(ADDR_DELAY, TIME_MAX_MS);
        wr(ADDR_CTRL, 32'h0);
        rdc(ADDR_DELAY, 32'h0);
        wr(ADDR_MASK, 32'h1F);
        a0 = n_act;
        s0 = n_store;
        cmd(CMD_INIT);
        wait_trig();
        repeat (2) @(posedge clk_in);
        #1;
        `CHK("irq", 1'b1, irq_out)
        rdc(ADDR_STATUS, 32'hE);
        `CHK("actions", 1, n_act - a0)
        `CHK("stores", 0, n_store - s0)
        repeat (3) @(posedge clk_in);
        #1;
        `CHK("irq", 1'b0, irq_out)
        wr(ADDR_SOURCE, 32'h3);
        cmd(CMD_INIT);
        rdc(ADDR_STATE, 32'h1);
        cmd(CMD_INIT);
        cmd(CMD_BUSTRIG);
        wait_trig();
        rdc(ADDR_STATUS, 32'hF);
        wr(ADDR_SOURCE, 32'h2);
        cmd(CMD_SIGNAL);
        rdc(ADDR_STATUS, 32'h1);
        foreach (rel[k]) begin
            cmd(CMD_INIT);
            cmd(rel[k]);
            wait_trig();
            rdc(ADDR_STATUS, 32'hE);
        end
        wr(ADDR_SOURCE, 32'h4);
        cmd(CMD_INIT);
        rdc(ADDR_STATE, 32'h1);
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
        wait_trig();
        wr(ADDR_TIMER, 32'h1);
        wr(ADDR_SOURCE, 32'h1);
        wr(ADDR_TCOUNT, 32'h2);
        cmd(CMD_INIT);
        wait_trig();
        rdc(ADDR_STATE, 32'h2);
        cmd(CMD_ABORT);
        rdc(ADDR_STATE, 32'h0);
        wr(ADDR_SOURCE, 32'h0);
        wr(ADDR_SCOUNT, 32'h3);
        wr(ADDR_TCOUNT, 32'h2);
        a0 = n_act;
        s0 = n_store;
        t0 = n_trig;
        cmd(CMD_INIT);
        wait_trig();
        wait_trig();
        repeat (10) @(posedge clk_in);
        #1;
        `CHK("actions", 6, n_act - a0)
        `CHK("stores", 6, n_store - s0)
        `CHK("out triggers", 2, n_trig - t0)
        wr(ADDR_SCOUNT, 32'h1);
        wr(ADDR_TCOUNT, 32'h1);
        rd(ADDR_STATUS);
        cmd(CMD_READ);
        wait_trig();
        repeat (4) @(posedge clk_in);
        rd(ADDR_STATUS);
        `CHK("read flow", 2'h3, {v[ST_FETCH], v[ST_OUTTRIG]})
        cmd(CMD_PRESET);
        rdc(ADDR_TCOUNT, {15'h0, COUNT_UNBOUNDED});
        rd(ADDR_CTRL);
        `CHK("continuous", 1'b1, v[CTRL_CONT])
        rd(ADDR_STATUS);
        wr(ADDR_SCOUNT, 32'h2);
        rdc(ADDR_SCOUNT, 32'h1);
        rd(ADDR_STATUS);
        `CHK("error flag", 1'b1, v[ST_ERR])
        cmd(CMD_READ);
        rd(ADDR_STATUS);
        `CHK("error flag", 1'b1, v[ST_ERR])
        cmd(CMD_ABORT);
        rd(ADDR_STATE);
        `CHK("restarted", 1'b1, v != 32'h0)
        cmd(CMD_RST);
        check_defaults();
        cmd(CMD_ABORT);
        rdc(ADDR_STATE, 32'h0);
        wr(ADDR_MASK, 32'h0);
        repeat (3) @(posedge clk_in);
        #1;
        `CHK("irq", 1'b0, irq_out)
        stop_test();
    end
endmodule

bind mtseq_top mtseq_monitor i_mon (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .link_trig_in(link_trig_in), .rdata_out(rdata_out), .out_trig_out(out_trig_out),
    .action_out(action_out), .store_out(store_out), .irq_out(irq_out));
